/* File: verilog/superio_watchdog_config.sv */
// Function
// - reset: config locked, keyboard unit enabled only if strap set
// - keyboard unit enable taken from strap
// - key 87 01 55 55 unlocks configuration
// - unlocked: index port 2Eh, data 2Fh
// - registers reachable only in configuration mode
// - index 07h selects logical device routing
// - control bit 1 exits to key wait
// - config control write only, one-shot bits
// - control bit 0 restores power-on values
// - watchdog regs device 07h, 71h-73h, reset 00h
// - infrared interrupt restarts count when enabled
// - mouse or keyboard interrupt restarts count
// - game port access restarts count
// - force time-out bit, self clearing
// - status bit set when count reaches zero
// - unit select and pulsed reset enable
// - eight-bit time-out value register
// - interrupt line select, zero selects none
module superio_watchdog_config
  import wdt_cfg_pkg::*;
#(
  parameter int unsigned  SECOND_TICKS   = SECOND_CYCLES,
  parameter logic [15:0]  GAME_PORT_BASE = 16'h0201
) (
  input  wire logic        CLK_IN,
  input  wire logic        RST_IN,
  input  wire logic [15:0] IO_ADDR_IN,
  input  wire logic        IO_WR_IN,
  input  wire logic        IO_RD_IN,
  input  wire logic [7:0]  IO_WDATA_IN,
  output logic      [7:0]  IO_RDATA_OUT,
  input  wire logic        KBD_ENABLE_STRAP_IN,
  input  wire logic        IR_IRQ_IN,
  input  wire logic        MOUSE_IRQ_IN,
  input  wire logic        KBD_IRQ_IN,
  output logic             CONFIG_MODE_OUT,
  output logic             KBD_UNIT_ENABLE_OUT,
  output logic             WDT_STATUS_OUT,
  output logic             PULSED_RESET_OUT,
  output logic      [15:0] IRQ_LINES_OUT
);

  key_state_e  key_state;
  key_state_e  restart_key;
  logic [7:0]  index;
  logic [7:0]  logical_device_number;
  logic [7:0]  wdt_ctrl;
  logic [7:0]  wdt_cfg;
  logic [7:0]  wdt_time;
  logic [7:0]  watchdog_counter;
  logic        wdt_status;
  logic        strap_taken;
  logic        strap_value;
  logic [2:0]  irq_prev;
  logic [2:0]  irq_rise;
  logic [5:0]  min_cnt;
  logic [7:0]  pulse_cnt;
  logic        sec_tick;
  logic        unit_tick;
  logic        idx_wr;
  logic        idx_rd;
  logic        data_wr;
  logic        data_rd;
  logic        cfg_on;
  logic        wdt_sel;
  logic        reg_wr;
  logic        cc_write;
  logic        cfg_exit;
  logic        cfg_reset;
  logic        wc_write;
  logic        cf_write;
  logic        time_write;
  logic        force_out;
  logic        game_hit;
  logic        restart;
  logic        expire;
  logic [3:0]  irq_sel;

  // port decode
  assign idx_wr  = IO_WR_IN && (IO_ADDR_IN == INDEX_PORT);
  assign idx_rd  = IO_RD_IN && (IO_ADDR_IN == INDEX_PORT);
  assign data_wr = IO_WR_IN && (IO_ADDR_IN == DATA_PORT);
  assign data_rd = IO_RD_IN && (IO_ADDR_IN == DATA_PORT);
  assign cfg_on  = (key_state == CFG_ACTIVE);
  assign wdt_sel = (logical_device_number == LDN_WATCHDOG);
  assign reg_wr  = cfg_on && data_wr;

  // one-shot commands, nothing is stored
  assign cc_write  = reg_wr && (index == IDX_CFG_CTRL);
  assign cfg_exit  = cc_write && IO_WDATA_IN[CC_EXIT_BIT];
  assign cfg_reset = cc_write && IO_WDATA_IN[CC_RESET_BIT];

  assign wc_write   = reg_wr && wdt_sel && (index == IDX_WDT_CTRL);
  assign cf_write   = reg_wr && wdt_sel && (index == IDX_WDT_CFG);
  assign time_write = reg_wr && wdt_sel && (index == IDX_WDT_TIME);
  assign force_out  = wc_write && IO_WDATA_IN[WC_FORCE_BIT];
  assign irq_sel    = wdt_cfg[CF_IRQ_MSB:CF_IRQ_LSB];

  // a wrong byte restarts the key, but may itself be a new first byte
  assign restart_key = (IO_WDATA_IN == KEY_BYTE0) ? KEY_GOT1 : KEY_WAIT;

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      key_state <= KEY_WAIT;
    end else begin
      case (key_state)
        KEY_WAIT: begin
          if (idx_wr) begin
            key_state <= restart_key;
          end
        end
        KEY_GOT1: begin
          if (idx_wr) begin
            key_state <= (IO_WDATA_IN == KEY_BYTE1) ? KEY_GOT2 : restart_key;
          end
        end
        KEY_GOT2: begin
          if (idx_wr) begin
            key_state <= (IO_WDATA_IN == KEY_BYTE2) ? KEY_GOT3 : restart_key;
          end
        end
        KEY_GOT3: begin
          if (idx_wr) begin
            key_state <= (IO_WDATA_IN == KEY_BYTE3) ? CFG_ACTIVE : restart_key;
          end
        end
        CFG_ACTIVE: begin
          if (cfg_exit) begin
            key_state <= KEY_WAIT;
          end
        end
        default: begin
          key_state <= KEY_WAIT;
        end
      endcase
    end
  end

  // index and logical device selection
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      index                 <= REG_RESET;
      logical_device_number <= REG_RESET;
    end else begin
      if (cfg_on && idx_wr) begin
        index <= IO_WDATA_IN;
      end
      if (cfg_reset) begin
        logical_device_number <= REG_RESET;
      end else if (reg_wr && (index == IDX_LDN)) begin
        logical_device_number <= IO_WDATA_IN;
      end
    end
  end

  // strap caught on the first edge after reset release
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      strap_taken         <= 1'b0;
      strap_value         <= 1'b0;
      KBD_UNIT_ENABLE_OUT <= 1'b0;
    end else if (!strap_taken) begin
      strap_taken         <= 1'b1;
      strap_value         <= KBD_ENABLE_STRAP_IN;
      KBD_UNIT_ENABLE_OUT <= KBD_ENABLE_STRAP_IN;
    end else if (cfg_reset) begin
      KBD_UNIT_ENABLE_OUT <= strap_value;
    end
  end

  // watchdog registers
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      wdt_ctrl <= REG_RESET;
      wdt_cfg  <= REG_RESET;
      wdt_time <= REG_RESET;
    end else if (cfg_reset) begin
      wdt_ctrl <= REG_RESET;
      wdt_cfg  <= REG_RESET;
      wdt_time <= REG_RESET;
    end else begin
      if (wc_write) begin
        wdt_ctrl <= IO_WDATA_IN & WC_STORE_MASK;
      end
      if (cf_write) begin
        wdt_cfg <= IO_WDATA_IN & CF_STORE_MASK;
      end
      if (time_write) begin
        wdt_time <= IO_WDATA_IN;
      end
    end
  end

  // restart sources; interrupts are taken on their rising edge
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      irq_prev <= 3'h0;
    end else begin
      irq_prev <= {IR_IRQ_IN, MOUSE_IRQ_IN, KBD_IRQ_IN};
    end
  end

  assign irq_rise = {IR_IRQ_IN, MOUSE_IRQ_IN, KBD_IRQ_IN} & ~irq_prev;
  assign game_hit = (IO_RD_IN || IO_WR_IN) && (IO_ADDR_IN == GAME_PORT_BASE);
  assign restart  = (irq_rise[2] && wdt_ctrl[WC_IR_BIT])
                 || (irq_rise[1] && wdt_ctrl[WC_MOUSE_BIT])
                 || (irq_rise[0] && wdt_ctrl[WC_KBD_BIT])
                 || (game_hit && wdt_ctrl[WC_GAME_BIT]);

  // time base
  tick_divider #(
    .DIVIDE   (SECOND_TICKS)
  ) second_div (
    .clk_in   (CLK_IN),
    .rst_in   (RST_IN),
    .tick_out (sec_tick)
  );

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      min_cnt <= 6'h00;
    end else if (sec_tick) begin
      min_cnt <= (min_cnt == MINUTE_LAST_SEC) ? 6'h00 : min_cnt + 6'h01;
    end
  end

  assign unit_tick = wdt_cfg[CF_UNIT_BIT] ? sec_tick
                   : (sec_tick && (min_cnt == MINUTE_LAST_SEC));

  assign expire = force_out
               || (unit_tick && (watchdog_counter == 8'h01) && !restart
                   && !time_write && !cfg_reset);

  // count: explicit loads beat the tick
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      watchdog_counter <= REG_RESET;
    end else if (cfg_reset) begin
      watchdog_counter <= REG_RESET;
    end else if (force_out) begin
      watchdog_counter <= REG_RESET;
    end else if (time_write) begin
      watchdog_counter <= IO_WDATA_IN;
    end else if (restart) begin
      watchdog_counter <= wdt_time;
    end else if (unit_tick && (watchdog_counter != 8'h00)) begin
      watchdog_counter <= watchdog_counter - 8'h01;
    end
  end

  // status: a clearing load in the same cycle blocks the tick's set; a forced set wins over a restart
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      wdt_status <= 1'b0;
    end else if (expire) begin
      wdt_status <= 1'b1;
    end else if (cfg_reset) begin
      wdt_status <= 1'b0;
    end else if (time_write && (IO_WDATA_IN != 8'h00)) begin
      wdt_status <= 1'b0;
    end else if (restart && (wdt_time != 8'h00)) begin
      wdt_status <= 1'b0;
    end
  end

  assign WDT_STATUS_OUT  = wdt_status;
  assign CONFIG_MODE_OUT = cfg_on;

  // reset pulse on time-out
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      pulse_cnt        <= 8'h00;
      PULSED_RESET_OUT <= 1'b0;
    end else if (expire && wdt_cfg[CF_PULSE_BIT]) begin
      pulse_cnt        <= PULSE_CYCLES;
      PULSED_RESET_OUT <= 1'b1;
    end else if (pulse_cnt != 8'h00) begin
      pulse_cnt        <= pulse_cnt - 8'h01;
      PULSED_RESET_OUT <= (pulse_cnt != 8'h01);
    end
  end

  // interrupt line held while status is set
  for (genvar i = 0; i < IRQ_LINES; i++) begin : g_irq
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
        IRQ_LINES_OUT[i] <= 1'b0;
      end else begin
        IRQ_LINES_OUT[i] <= wdt_status && (irq_sel != 4'h0)
                         && (irq_sel == 4'(i));
      end
    end
  end

  // read path; outside configuration mode the data port floats high
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      IO_RDATA_OUT <= FLOAT_READ;
    end else if (cfg_on && idx_rd) begin
      IO_RDATA_OUT <= index;
    end else if (cfg_on && data_rd) begin
      case (index)
        IDX_LDN:      IO_RDATA_OUT <= logical_device_number;
        IDX_WDT_CTRL: IO_RDATA_OUT <= wdt_sel ?
                        (wdt_ctrl | {7'h00, wdt_status}) : REG_RESET;
        IDX_WDT_CFG:  IO_RDATA_OUT <= wdt_sel ? wdt_cfg : REG_RESET;
        IDX_WDT_TIME: IO_RDATA_OUT <= wdt_sel ? wdt_time : REG_RESET;
        default:      IO_RDATA_OUT <= REG_RESET;
      endcase
    end else if (data_rd || idx_rd) begin
      IO_RDATA_OUT <= FLOAT_READ;
    end
  end

  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (RST_IN);

  key_unlock_a: assert property (
    (key_state == KEY_GOT3) && idx_wr && (IO_WDATA_IN == KEY_BYTE3)
    |=> CONFIG_MODE_OUT)
    else $error("key sequence did not unlock");
  cfg_exit_a: assert property (
    cfg_exit |=> !CONFIG_MODE_OUT [*2])
    else $error("exit command did not relock");
  locked_write_a: assert property (
    !cfg_on && data_wr |=> $stable(wdt_time) && $stable(wdt_cfg))
    else $error("register changed while locked");
  cfg_restore_a: assert property (
    cfg_reset |=> (wdt_ctrl == REG_RESET) && (wdt_time == REG_RESET)
      && (logical_device_number == REG_RESET) && !wdt_status)
    else $error("configuration reset incomplete");
  ldn_route_a: assert property (
    reg_wr && (index == IDX_WDT_TIME) && !wdt_sel |=> $stable(wdt_time))
    else $error("write reached unselected device");
  force_tmo_a: assert property (
    force_out |=> wdt_status && (watchdog_counter == 8'h00)
      && !wdt_ctrl[WC_FORCE_BIT])
    else $error("force did not time out");
  restart_load_a: assert property (
    restart && !time_write && !cfg_reset && !force_out
    |=> (watchdog_counter == $past(wdt_time)))
    else $error("restart did not reload count");
  count_dec_a: assert property (
    unit_tick && (watchdog_counter > 8'h01) && !restart && !reg_wr
    |=> (watchdog_counter == $past(watchdog_counter) - 8'h01))
    else $error("count did not decrement");
  status_zero_a: assert property (
    wdt_status |-> (watchdog_counter == 8'h00))
    else $error("status set with nonzero count");
  reset_pulse_a: assert property (
    expire && wdt_cfg[CF_PULSE_BIT] |=> PULSED_RESET_OUT [*8])
    else $error("reset pulse too short");
  irq_line_a: assert property (
    (irq_sel == 4'h0) |=> (IRQ_LINES_OUT == 16'h0000))
    else $error("interrupt raised with none selected");
  strap_take_a: assert property (
    !strap_taken |=> KBD_UNIT_ENABLE_OUT == $past(KBD_ENABLE_STRAP_IN))
    else $error("strap not captured");

  unlock_c: cover property (key_state == KEY_GOT3 ##1 cfg_on);
  expire_c: cover property (expire && !force_out);
  restart_c: cover property (restart && (wdt_time != 8'h00));
  pulse_c: cover property ($fell(PULSED_RESET_OUT));

endmodule : superio_watchdog_config

/* File: verilog/wdt_cfg_pkg.sv */
package wdt_cfg_pkg;

  // host i/o ports
  localparam logic [15:0] INDEX_PORT      = 16'h002e;
  localparam logic [15:0] DATA_PORT       = 16'h002f;

  // unlock key, written in this order to the index port
  localparam logic [7:0]  KEY_BYTE0       = 8'h87;
  localparam logic [7:0]  KEY_BYTE1       = 8'h01;
  localparam logic [7:0]  KEY_BYTE2       = 8'h55;
  localparam logic [7:0]  KEY_BYTE3       = 8'h55;

  // configuration indices
  localparam logic [7:0]  IDX_CFG_CTRL    = 8'h02;
  localparam logic [7:0]  IDX_LDN         = 8'h07;
  localparam logic [7:0]  IDX_WDT_CTRL    = 8'h71;
  localparam logic [7:0]  IDX_WDT_CFG     = 8'h72;
  localparam logic [7:0]  IDX_WDT_TIME    = 8'h73;
  localparam logic [7:0]  LDN_WATCHDOG    = 8'h07;

  // config_control bits
  localparam int          CC_RESET_BIT    = 0;
  localparam int          CC_EXIT_BIT     = 1;

  // watchdog_control bits
  localparam int          WC_IR_BIT       = 7;
  localparam int          WC_MOUSE_BIT    = 6;
  localparam int          WC_KBD_BIT      = 5;
  localparam int          WC_GAME_BIT     = 4;
  localparam int          WC_FORCE_BIT    = 1;
  localparam logic [7:0]  WC_STORE_MASK   = 8'hf0;

  // watchdog_configuration bits
  localparam int          CF_UNIT_BIT     = 7;
  localparam int          CF_PULSE_BIT    = 6;
  localparam int          CF_IRQ_MSB      = 3;
  localparam int          CF_IRQ_LSB      = 0;
  localparam logic [7:0]  CF_STORE_MASK   = 8'hcf;

  localparam logic [7:0]  REG_RESET       = 8'h00;
  localparam logic [7:0]  FLOAT_READ      = 8'hff;
  localparam int          IRQ_LINES       = 16;

  // timing
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned SECOND_NS       = 1000000000;
  localparam int unsigned SECOND_CYCLES   = SECOND_NS / CLK_PERIOD_NS;
  localparam logic [5:0]  MINUTE_LAST_SEC = 6'd59;
  localparam int unsigned PULSE_NS        = 640;
  localparam int unsigned PULSE_CYCLES_I  = PULSE_NS / CLK_PERIOD_NS;
  localparam logic [7:0]  PULSE_CYCLES    = 8'(PULSE_CYCLES_I);

  typedef enum {
    KEY_WAIT,
    KEY_GOT1,
    KEY_GOT2,
    KEY_GOT3,
    CFG_ACTIVE
  } key_state_e;

endpackage : wdt_cfg_pkg

/* File: verilog/tick_divider.sv */
module tick_divider #(
  parameter int unsigned DIVIDE = 100
) (
  input  wire logic clk_in,
  input  wire logic rst_in,
  output logic      tick_out
);

  localparam int unsigned CW = (DIVIDE > 1) ? $clog2(DIVIDE) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIVIDE - 1);
  localparam logic [CW-1:0] ONE  = CW'(1);

  logic [CW-1:0] count;

  // free running, so the first unit may be short by up to one period
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      count    <= '0;
      tick_out <= 1'b0;
    end else if (count == LAST) begin
      count    <= '0;
      tick_out <= 1'b1;
    end else begin
      count    <= count + ONE;
      tick_out <= 1'b0;
    end
  end

endmodule : tick_divider

/* File: verification/host_model.sv */
module host_model
  import wdt_cfg_pkg::*;
(
  input  wire logic        clk_in,
  output logic      [15:0] addr_out,
  output logic             wr_out,
  output logic             rd_out,
  output logic      [7:0]  wdata_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    addr_out  = 16'h0000;
    wr_out    = 1'b0;
    rd_out    = 1'b0;
    wdata_out = 8'h00;
  end

  // one strobe per access, then an idle cycle before the next
  task automatic access(input logic [15:0] a, input logic w,
                        input logic [7:0] d);
    @(negedge clk_in);
    addr_out  = a;
    wr_out    = w;
    rd_out    = ~w;
    wdata_out = d;
    @(negedge clk_in);
    wr_out    = 1'b0;
    rd_out    = 1'b0;
    // released bus shows the inverse, never the stale value
    addr_out  = ~a;
    wdata_out = ~d;
  endtask : access

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    access(a, 1'b1, d);
  endtask : wr

  task automatic rd(input logic [15:0] a);
    access(a, 1'b0, ~wdata_out);
  endtask : rd

  task automatic unlock();
    wr(INDEX_PORT, KEY_BYTE0);
    wr(INDEX_PORT, KEY_BYTE1);
    wr(INDEX_PORT, KEY_BYTE2);
    wr(INDEX_PORT, KEY_BYTE3);
  endtask : unlock

  task automatic sel_ldn(input logic [7:0] n);
    wr(INDEX_PORT, IDX_LDN);
    wr(DATA_PORT, n);
  endtask : sel_ldn

  task automatic exit_cfg();
    wr(INDEX_PORT, IDX_CFG_CTRL);
    wr(DATA_PORT, 8'h02);
  endtask : exit_cfg
endmodule : host_model

/* File: verification/tb.sv */
module tb
  import wdt_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // short second keeps the minute unit at 600 cycles
  localparam int unsigned TICKS = 10;
  localparam logic [15:0] GAME  = 16'h0201;

  logic        clk;
  logic        rst;
  logic        strap;
  logic [2:0]  ev;
  logic [15:0] addr;
  logic        wr;
  logic        rd;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic        cfg_mode;
  logic        kbd_en;
  logic        status;
  logic        pulse;
  logic [15:0] irq;
  logic        chk = 1'b0;
  logic [7:0]  exp_q[$];
  logic [7:0]  v;
  logic [3:0]  sel;
  int          error_cnt = 0;
  int          n_tests = 0;

  host_model host (.clk_in(clk), .addr_out(addr), .wr_out(wr), .rd_out(rd),
                   .wdata_out(wdata));

  superio_watchdog_config #(.SECOND_TICKS(TICKS), .GAME_PORT_BASE(GAME)) DUT (
    .CLK_IN(clk), .RST_IN(rst), .IO_ADDR_IN(addr), .IO_WR_IN(wr),
    .IO_RD_IN(rd), .IO_WDATA_IN(wdata), .IO_RDATA_OUT(rdata),
    .KBD_ENABLE_STRAP_IN(strap), .IR_IRQ_IN(ev[0]), .MOUSE_IRQ_IN(ev[1]),
    .KBD_IRQ_IN(ev[2]), .CONFIG_MODE_OUT(cfg_mode),
    .KBD_UNIT_ENABLE_OUT(kbd_en), .WDT_STATUS_OUT(status),
    .PULSED_RESET_OUT(pulse), .IRQ_LINES_OUT(irq));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic cmp_rd(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected read at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : cmp_rd

  task automatic cmp_pin(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected pin at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : cmp_pin

  // read data lands one cycle after the strobe
  always @(posedge clk) chk <= rd && (addr == INDEX_PORT || addr == DATA_PORT);
  always @(negedge clk) begin
    if (chk === 1'b1 && exp_q.size() > 0) cmp_rd(rdata, exp_q.pop_front());
  end

  task automatic rdx(input logic [7:0] idx, input logic [7:0] exp);
    host.wr(INDEX_PORT, idx);
    exp_q.push_back(exp);
    host.rd(DATA_PORT);
  endtask : rdx

  task automatic wrx(input logic [7:0] idx, input logic [7:0] d);
    host.wr(INDEX_PORT, idx);
    host.wr(DATA_PORT, d);
  endtask : wrx

  // k 0..2 interrupt inputs, 3 game port access
  task automatic fire(input int k);
    if (k == 3) host.rd(GAME);
    else begin
      @(negedge clk);
      ev[k] = 1'b1;
      @(negedge clk);
      ev[k] = 1'b0;
    end
  endtask : fire

  task automatic wait_status(input int lim);
    for (int i = 0; i < lim && status !== 1'b1; i++) @(negedge clk);
  endtask : wait_status

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize

  initial begin
    repeat (20000) @(posedge clk);
    $display("watchdog expired at %0t", $time);
    error_cnt++;
    summarize();
  end

  initial begin
    rst = 1'b1;
    ev = 3'b000;
    void'($urandom(14767));
    strap = 1'($urandom);
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    cmp_pin(16'(cfg_mode), 16'h0000);
    cmp_pin(16'(kbd_en), 16'(strap));
    cmp_pin(irq | 16'({status, pulse}), 16'h0000);
    exp_q.push_back(FLOAT_READ);
    host.rd(DATA_PORT);
    host.wr(DATA_PORT, 8'h02);
    host.wr(INDEX_PORT, KEY_BYTE0);
    host.wr(INDEX_PORT, KEY_BYTE1);
    host.wr(INDEX_PORT, KEY_BYTE2);
    host.wr(INDEX_PORT, 8'haa);
    cmp_pin(16'(cfg_mode), 16'h0000);
    host.unlock();
    cmp_pin(16'(cfg_mode), 16'h0001);
    $display("test lock done");

    host.sel_ldn(LDN_WATCHDOG);
    exp_q.push_back(IDX_LDN);
    host.rd(INDEX_PORT);
    for (int i = 0; i < 3; i++) rdx(IDX_WDT_CTRL + 8'(i), REG_RESET);
    v = 8'($urandom) & 8'hfc;
    wrx(IDX_WDT_CTRL, v);
    rdx(IDX_WDT_CTRL, v & WC_STORE_MASK);
    v = 8'($urandom);
    wrx(IDX_WDT_CFG, v);
    rdx(IDX_WDT_CFG, v & CF_STORE_MASK);
    v = 8'($urandom_range(255, 16));
    wrx(IDX_WDT_TIME, v);
    rdx(IDX_WDT_TIME, v);
    rdx(IDX_CFG_CTRL, 8'h00);
    host.sel_ldn(8'h08);
    rdx(IDX_LDN, 8'h08);
    rdx(IDX_WDT_TIME, 8'h00);
    wrx(IDX_CFG_CTRL, 8'h01);
    cmp_pin(16'(cfg_mode), 16'h0001);
    cmp_pin(16'(kbd_en), 16'(strap));
    rdx(IDX_LDN, 8'h00);
    host.sel_ldn(LDN_WATCHDOG);
    for (int i = 0; i < 3; i++) rdx(IDX_WDT_CTRL + 8'(i), REG_RESET);
    $display("test registers done");

    wrx(IDX_WDT_CFG, 8'h80);
    wrx(IDX_WDT_TIME, 8'h03);
    repeat (15) @(negedge clk);
    cmp_pin(16'(status), 16'h0000);
    wait_status(40);
    cmp_pin(16'(status), 16'h0001);
    rdx(IDX_WDT_CTRL, 8'h01);
    wrx(IDX_WDT_CFG, 8'h00);
    wrx(IDX_WDT_TIME, 8'h02);
    repeat (550) @(negedge clk);
    cmp_pin(16'(status), 16'h0000);
    wait_status(1300);
    cmp_pin(16'(status), 16'h0001);
    $display("test countdown done");

    // events every 8 cycles beat a two-unit expiry of 11 cycles or more
    wrx(IDX_WDT_CFG, 8'h80);
    for (int k = 0; k < 4; k++) begin
      for (int en = 0; en < 2; en++) begin
        wrx(IDX_WDT_CTRL, en != 0 ? (8'h80 >> k) : 8'h00);
        wrx(IDX_WDT_TIME, 8'h02);
        repeat (6) begin
          fire(k);
          repeat (6) @(negedge clk);
        end
        cmp_pin(16'(status), 16'(en == 0));
        wait_status(30);
        cmp_pin(16'(status), 16'h0001);
      end
    end
    $display("test restarts done");

    sel = 4'($urandom_range(15, 1));
    for (int j = 0; j < 2; j++) begin
      wrx(IDX_WDT_CFG, {4'h4, j != 0 ? sel : 4'h0});
      wrx(IDX_WDT_TIME, 8'hc8);
      wrx(IDX_WDT_CTRL, 8'h02);
      cmp_pin(16'({status, pulse}), 16'h0003);
      @(negedge clk);
      cmp_pin(irq, j != 0 ? 16'h0001 << sel : 16'h0000);
      repeat (58) @(negedge clk);
      cmp_pin(16'(pulse), 16'h0001);
      repeat (8) @(negedge clk);
      cmp_pin(16'(pulse), 16'h0000);
      rdx(IDX_WDT_CTRL, 8'h01);
    end
    $display("test force done");

    host.exit_cfg();
    cmp_pin(16'(cfg_mode), 16'h0000);
    exp_q.push_back(FLOAT_READ);
    host.rd(DATA_PORT);
    repeat (2) @(negedge clk);
    $display("test exit done");
    summarize();
  end
endmodule : tb
